// ### hdl/mfrl_pkg.sv
// Shared constants, types and helpers for the motor fault-response block
package mfrl_pkg;

  // Register byte offsets
  localparam logic [7:0] MFRL_CFG_OFS      = 8'h00;
  localparam logic [7:0] MFRL_THR_OFS      = 8'h04;
  localparam logic [7:0] MFRL_STATUS_OFS   = 8'h08;
  localparam logic [7:0] MFRL_CLEAR_OFS    = 8'h0c;
  localparam logic [7:0] MFRL_IRQ_STAT_OFS = 8'h10;
  localparam logic [7:0] MFRL_IRQ_CLR_OFS  = 8'h14;
  localparam logic [7:0] MFRL_IRQ_EN_OFS   = 8'h18;

  // Field positions
  localparam int MFRL_CLR_BIT     = 0;   // fault_clear_bit in clear word
  localparam int MFRL_THR_CUR_LSB = 16;  // lock current threshold
  localparam int MFRL_STAT_GS_LSB = 10;  // gate state in status word

  // Values after reset: both response fields 1001b (ignore)
  localparam logic [23:0] MFRL_CFG_RST = 24'h000099;
  localparam logic [27:0] MFRL_THR_RST = 28'hfffffff;
  localparam logic [3:0]  MFRL_IRQ_RST = 4'h0;

  // Timing
  localparam int MFRL_CLK_NS       = 8;          // 125 MHz
  localparam int MFRL_DEG_UNIT_NS  = 1000;       // deglitch step, 1 us
  localparam int MFRL_RETRY_UNIT_NS = 1000000;   // retry step, 1 ms
  localparam int MFRL_DEG_UNIT_CYC = MFRL_DEG_UNIT_NS / MFRL_CLK_NS;
  localparam int MFRL_RETRY_UNIT_CYC = MFRL_RETRY_UNIT_NS / MFRL_CLK_NS;
  localparam int MFRL_TMR_W        = 24;         // timer width

  // Configuration word (low 24 bits of the config register)
  typedef struct packed {
    logic [7:0] lock_deglitch;               // steps of 1 us
    logic       no_load_check_enable;
    logic       sync_loss_check_enable;
    logic       overspeed_check_enable;
    logic       warning_pin_report_enable;
    logic [3:0] stall_retry_time_field;
    logic [3:0] motor_stall_response_field;
    logic [3:0] lock_current_response_field;
  } mfrl_cfg_t;

  // Temperature comparator levels, true while above the limit
  typedef struct packed {
    logic tsd_hys_above;  // above shutdown limit minus hysteresis
    logic tsd_above;      // above shutdown limit
    logic otw_hys_above;  // above warning limit minus hysteresis
    logic otw_above;      // above warning limit
  } mfrl_temp_t;

  // Lock cause flags
  typedef struct packed {
    logic no_load;
    logic sync_loss;
    logic overspeed;
  } mfrl_cause_t;

  // Decoded response of a 4-bit response field
  typedef enum logic [1:0] {
    MFRL_ACT_LATCH  = 2'b00,
    MFRL_ACT_RETRY  = 2'b01,
    MFRL_ACT_REPORT = 2'b10,
    MFRL_ACT_IGNORE = 2'b11
  } mfrl_act_t;

  // Power stage state driven out
  typedef enum logic [2:0] {
    MFRL_GS_RUN    = 3'b000,
    MFRL_GS_OFF    = 3'b001,
    MFRL_GS_RECIRC = 3'b010,
    MFRL_GS_HS_ON  = 3'b011,
    MFRL_GS_LS_ON  = 3'b100
  } mfrl_gate_t;

  // Protection state machine
  typedef enum logic [1:0] {
    MFRL_PR_IDLE  = 2'b00,
    MFRL_PR_LATCH = 2'b01,
    MFRL_PR_RETRY = 2'b10
  } mfrl_prot_t;

  // Response field decode, shared by both event sources
  function automatic mfrl_act_t mfrl_act_of(input logic [3:0] m);
    if (!m[3])
      return m[2] ? MFRL_ACT_RETRY : MFRL_ACT_LATCH;
    else if (m == 4'h8)
      return MFRL_ACT_REPORT;
    else
      return MFRL_ACT_IGNORE;
  endfunction : mfrl_act_of

  // Power stage for the two low bits of a response field
  function automatic mfrl_gate_t mfrl_stage_of(input logic [1:0] low2,
                                               input logic recirc_over);
    unique case (low2)
      2'b00:   return MFRL_GS_OFF;
      2'b01:   return recirc_over ? MFRL_GS_OFF : MFRL_GS_RECIRC;
      2'b10:   return MFRL_GS_HS_ON;
      default: return MFRL_GS_LS_ON;
    endcase
  endfunction : mfrl_stage_of

endpackage : mfrl_pkg

// ### hdl/mfrl_timer.sv
// Reloadable down-counter used for deglitch and retry timing
`timescale 1ns/1ps
module mfrl_timer (
  input  wire logic                           hclk,
  input  wire logic                           hresetn,
  input  wire logic                           run,
  input  wire logic [mfrl_pkg::MFRL_TMR_W-1:0] load_val,
  output logic                                expired
);
  import mfrl_pkg::*;

  logic [MFRL_TMR_W-1:0] count;  // Remaining cycles
  wire                   at_zero = (count == '0);

  // Reload while idle, count down while running, stop at zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      count <= '0;
    else if (!run)
      count <= load_val;
    else if (!at_zero)
      count <= count - 1'b1;
  end

  // Level, high while running and the count has run out
  assign expired = run && at_zero;

endmodule : mfrl_timer

// ### hdl/mfrl_fault_resp.sv
// Motor fault response: lock current, thermal and motor-stall handling
`timescale 1ns/1ps
// Function
// - Lock current report mode: flag, keep driving
// - Lock current 1xx1b: ignore events entirely
// - Warning temperature sets summary and warning flags
// - Warning drives fault pin only if enabled
// - Warning flag held until clear and cool
// - Shutdown: stage off, pump off, pin low
// - Shutdown ends automatically below hysteresis point
// - Shutdown flag held until clear; always active
// - Any enabled detector raises a stall event
// - Modes 00xx/01xx: pin low, stage from bits
// - Latched stall: resume after clear and cleared
// - Retry stall: resume and clear flags after timer
// - Stall report mode: flag only, keep driving
// - Stall 1xx1b: no action, no flags
// - Each detector has own enable bit
// - Overspeed above threshold raises lock event
// - Current over threshold past deglitch time
module mfrl_fault_resp #(
  parameter int RETRY_UNIT_CYC = mfrl_pkg::MFRL_RETRY_UNIT_CYC
) (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata,
  input  wire mfrl_pkg::mfrl_temp_t   temp_cmp,
  input  wire logic                   recirc_done,
  input  wire logic [11:0]            csa_code,
  input  wire logic [15:0]            motor_speed,
  input  wire logic                   sync_loss_detect,
  input  wire logic                   no_load_detect,
  output mfrl_pkg::mfrl_gate_t        gate_state,
  output logic                        charge_pump_en,
  output logic                        fault_pin_n,
  output logic                        irq
);
  import mfrl_pkg::*;

  // Pin synchronisers: first stage read only by second
  logic [4:0]  pin_meta;
  logic [4:0]  pin_sync;
  mfrl_temp_t  temp_s;
  logic        recirc_s;
  assign temp_s   = mfrl_temp_t'(pin_sync[3:0]);
  assign recirc_s = pin_sync[4];

  // Registers
  mfrl_cfg_t   cfg;           // Configuration
  logic [27:0] thr;           // Speed and current thresholds
  logic [3:0]  irq_stat;      // Sticky event bits
  logic [3:0]  irq_en;        // Interrupt enables

  // Fault state
  logic        ocl_flag;      // lock_current_threshold_flag
  logic        stall_flag;    // motor_stall_flag
  mfrl_cause_t cause_flag;    // Per-detector lock causes
  logic        otw_flag;      // thermal_warning_flag
  logic        tsd_flag;      // thermal_shutdown_flag
  logic        otw_pin;       // Warning pin state with hysteresis
  logic        tsd_active;    // Shutdown in force
  mfrl_prot_t  prot;          // Protection state
  logic        prot_src;      // 1: stall source, 0: lock current
  logic [1:0]  prot_low2;     // Stage code held at entry
  logic        recirc_over;   // Recirculation finished

  // AHB data-phase capture
  logic        dp_wr;
  logic [7:0]  dp_addr;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
    end else begin
      pin_meta <= {recirc_done, temp_cmp};
      pin_sync <= pin_meta;
    end
  end

  // Bus decode; zero-wait slave, always OKAY
  wire        addr_ph  = hsel && htrans[1] && hready;
  wire [7:0]  a_off    = haddr[7:0];
  wire        a_hit    = (haddr[31:8] == 24'h000000) && (a_off[1:0] == 2'b00);
  wire        wr_cfg   = dp_wr && (dp_addr == MFRL_CFG_OFS);
  wire        wr_thr   = dp_wr && (dp_addr == MFRL_THR_OFS);
  wire        wr_clr   = dp_wr && (dp_addr == MFRL_CLEAR_OFS);
  wire        wr_iclr  = dp_wr && (dp_addr == MFRL_IRQ_CLR_OFS);
  wire        wr_ien   = dp_wr && (dp_addr == MFRL_IRQ_EN_OFS);
  wire        clr_pulse = wr_clr && hwdata[MFRL_CLR_BIT];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Thresholds and live conditions
  wire [15:0] ovs_thr  = thr[15:0];
  wire [11:0] cur_thr  = thr[MFRL_THR_CUR_LSB +: 12];
  wire        cur_above = csa_code > cur_thr;
  mfrl_cause_t cause_now;
  assign cause_now.overspeed = cfg.overspeed_check_enable
                               && (motor_speed > ovs_thr);
  assign cause_now.sync_loss = cfg.sync_loss_check_enable
                               && sync_loss_detect;
  assign cause_now.no_load   = cfg.no_load_check_enable
                               && no_load_detect;
  wire        stall_cond = |cause_now;

  // Response decode
  mfrl_act_t  ocl_act;
  mfrl_act_t  stall_act;
  assign ocl_act   = mfrl_act_of(cfg.lock_current_response_field);
  assign stall_act = mfrl_act_of(cfg.motor_stall_response_field);

  // Deglitch of the lock current comparison
  logic [MFRL_TMR_W-1:0] deg_load;
  logic                  ocl_deg;
  assign deg_load = MFRL_TMR_W'(cfg.lock_deglitch * MFRL_DEG_UNIT_CYC);
  mfrl_timer u_deg (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .run      (cur_above),
    .load_val (deg_load),
    .expired  (ocl_deg)
  );

  // Retry wait, loaded with (field + 1) steps
  logic [MFRL_TMR_W-1:0] retry_load;
  logic                  retry_exp;
  assign retry_load = MFRL_TMR_W'((cfg.stall_retry_time_field + 5'd1)
                                  * RETRY_UNIT_CYC);
  mfrl_timer u_retry (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .run      (prot == MFRL_PR_RETRY),
    .load_val (retry_load),
    .expired  (retry_exp)
  );

  // Events; ignored and undefined codes produce nothing
  wire ocl_ev   = ocl_deg && (ocl_act != MFRL_ACT_IGNORE);
  wire stall_ev = stall_cond && (stall_act != MFRL_ACT_IGNORE);
  wire ocl_prot = ocl_ev && !ocl_act[1];
  wire stall_prot = stall_ev && !stall_act[1];

  // Protection transitions
  wire src_cond   = prot_src ? stall_cond : cur_above;
  wire latch_exit = (prot == MFRL_PR_LATCH) && !src_cond
                    && clr_pulse;
  wire retry_end  = (prot == MFRL_PR_RETRY) && retry_exp;
  wire retry_stall = retry_end && prot_src;
  wire retry_ocl   = retry_end && !prot_src;

  // Flag clears need the condition gone plus the clear command
  wire clr_ocl   = clr_pulse && !cur_above;
  wire clr_stall = clr_pulse && !stall_cond;
  wire clr_otw   = clr_pulse && !temp_s.otw_above;
  wire clr_tsd   = clr_pulse && !tsd_active;

  // Next protection state; stall wins if both arrive together
  mfrl_prot_t next_prot;
  logic       next_src;
  logic [1:0] next_low2;
  always_comb begin
    next_prot = prot;
    next_src  = prot_src;
    next_low2 = prot_low2;
    if (prot == MFRL_PR_IDLE) begin
      if (stall_prot) begin
        next_prot = stall_act[0] ? MFRL_PR_RETRY : MFRL_PR_LATCH;
        next_src  = 1'b1;
        next_low2 = cfg.motor_stall_response_field[1:0];
      end else if (ocl_prot) begin
        next_prot = ocl_act[0] ? MFRL_PR_RETRY : MFRL_PR_LATCH;
        next_src  = 1'b0;
        next_low2 = cfg.lock_current_response_field[1:0];
      end
    end else if (latch_exit || retry_end) begin
      next_prot = MFRL_PR_IDLE;
    end
  end

  // Output state
  mfrl_gate_t next_gate;
  assign next_gate = tsd_active ? MFRL_GS_OFF :
                     (prot != MFRL_PR_IDLE) ?
                       mfrl_stage_of(prot_low2, recirc_over) :
                       MFRL_GS_RUN;
  wire next_pin_n = !(tsd_active
                      || (cfg.warning_pin_report_enable && otw_pin)
                      || (prot != MFRL_PR_IDLE));

  // Interrupt events: first setting of each flag group
  wire [3:0] irq_ev = {tsd_flag ? 1'b0 : temp_s.tsd_above,
                       otw_flag ? 1'b0 : temp_s.otw_above,
                       stall_ev && !stall_flag,
                       ocl_ev && !ocl_flag};

  // Status word
  wire ctrl_fault = ocl_flag || stall_flag;
  wire ot_flag    = otw_flag || tsd_flag;
  wire [31:0] status_word = {19'h00000, gate_state, cause_flag,
                             stall_flag, ocl_flag, tsd_flag, otw_flag,
                             ot_flag, tsd_flag, ctrl_fault};

  // Read mux, unmapped reads as zero
  wire [31:0] rd_word =
    !a_hit                      ? 32'h00000000 :
    (a_off == MFRL_CFG_OFS)      ? {8'h00, cfg} :
    (a_off == MFRL_THR_OFS)      ? {4'h0, thr} :
    (a_off == MFRL_STATUS_OFS)   ? status_word :
    (a_off == MFRL_IRQ_STAT_OFS) ? {28'h0000000, irq_stat} :
    (a_off == MFRL_IRQ_EN_OFS)   ? {28'h0000000, irq_en} :
                                   32'h00000000;

  // Bus phases and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr   <= 1'b0;
      dp_addr <= 8'h00;
      hrdata  <= 32'h00000000;
    end else begin
      dp_wr   <= addr_ph && hwrite && a_hit;
      dp_addr <= a_off;
      if (addr_ph && !hwrite)
        hrdata <= rd_word;
    end
  end

  // Software registers; hsize ignored, only word access is used
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg    <= mfrl_cfg_t'(MFRL_CFG_RST);
      thr    <= MFRL_THR_RST;
      irq_en <= MFRL_IRQ_RST;
    end else begin
      if (wr_cfg)
        cfg <= mfrl_cfg_t'(hwdata[23:0]);
      if (wr_thr)
        thr <= hwdata[27:0];
      if (wr_ien)
        irq_en <= hwdata[3:0];
    end
  end

  // Sticky interrupt bits; a new event beats the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      irq_stat <= MFRL_IRQ_RST;
    else
      irq_stat <= irq_ev | (irq_stat & ~(wr_iclr ? hwdata[3:0] : 4'h0));
  end

  // Lock current and stall flags; retry expiry forces the flag of the retrying source low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ocl_flag   <= 1'b0;
      stall_flag <= 1'b0;
      cause_flag <= '0;
    end else begin
      if (retry_ocl)
        ocl_flag <= 1'b0;
      else if (ocl_ev)
        ocl_flag <= 1'b1;
      else if (clr_ocl)
        ocl_flag <= 1'b0;
      if (retry_stall) begin
        stall_flag <= 1'b0;
        cause_flag <= '0;
      end else if (stall_ev) begin
        stall_flag <= 1'b1;
        cause_flag <= cause_flag | cause_now;
      end else if (clr_stall) begin
        stall_flag <= 1'b0;
        cause_flag <= '0;
      end
    end
  end

  // Thermal flags and pin states with hysteresis
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      otw_flag   <= 1'b0;
      tsd_flag   <= 1'b0;
      otw_pin    <= 1'b0;
      tsd_active <= 1'b0;
    end else begin
      if (temp_s.otw_above)
        otw_flag <= 1'b1;
      else if (clr_otw)
        otw_flag <= 1'b0;
      if (temp_s.tsd_above)
        tsd_flag <= 1'b1;
      else if (clr_tsd)
        tsd_flag <= 1'b0;
      if (temp_s.otw_above)
        otw_pin <= 1'b1;
      else if (!temp_s.otw_hys_above)
        otw_pin <= 1'b0;
      // No configuration reaches this, shutdown cannot be disabled
      if (temp_s.tsd_above)
        tsd_active <= 1'b1;
      else if (!temp_s.tsd_hys_above)
        tsd_active <= 1'b0;
    end
  end

  // Protection state and recirculation tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prot        <= MFRL_PR_IDLE;
      prot_src    <= 1'b0;
      prot_low2   <= 2'b00;
      recirc_over <= 1'b0;
    end else begin
      prot        <= next_prot;
      prot_src    <= next_src;
      prot_low2   <= next_low2;
      recirc_over <= (prot != MFRL_PR_IDLE) && (recirc_over || recirc_s);
    end
  end

  // Registered outputs toward the power stage and the pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_state     <= MFRL_GS_RUN;
      charge_pump_en <= 1'b1;
      fault_pin_n    <= 1'b1;
      irq            <= 1'b0;
    end else begin
      gate_state     <= next_gate;
      charge_pump_en <= !tsd_active;
      fault_pin_n    <= next_pin_n;
      irq            <= |(irq_stat & irq_en);
    end
  end

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_retry_wait;
    (prot == MFRL_PR_RETRY) && retry_exp && prot_src;
  endsequence
  sequence s_resumed;
    (prot == MFRL_PR_IDLE) && !stall_flag;
  endsequence

  a_tsd_shut_off: assert property (tsd_active |=>
    (gate_state == MFRL_GS_OFF) && !charge_pump_en && !fault_pin_n)
    else $error("shutdown did not stop the stage");
  a_tsd_flag_hold: assert property (tsd_flag && !clr_pulse |=>
    tsd_flag) else $error("shutdown flag dropped without clear");
  a_tsd_resume: assert property (tsd_active && !temp_s.tsd_above
    && !temp_s.tsd_hys_above |=> !tsd_active)
    else $error("shutdown did not end below hysteresis");
  a_otw_flags_set: assert property ($rose(temp_s.otw_above) |=>
    otw_flag && ot_flag) else $error("warning flags not set");
  a_otw_pin_quiet: assert property (!cfg.warning_pin_report_enable
    && !tsd_active && (prot == MFRL_PR_IDLE) |=> fault_pin_n)
    else $error("fault pin low with nothing reported");
  a_otw_flag_keep: assert property (otw_flag && !clr_otw |=>
    otw_flag) else $error("warning flag lost early");
  a_ocl_ignored: assert property (!ocl_flag && ocl_act ==
    MFRL_ACT_IGNORE |=> !ocl_flag) else $error("ignored event flagged");
  a_retry_clears: assert property (s_retry_wait |=> s_resumed)
    else $error("retry expiry did not resume");
  a_latch_enter: assert property ((prot == MFRL_PR_IDLE) && stall_ev
    && (stall_act == MFRL_ACT_LATCH) ##1 !tsd_active |=> !fault_pin_n)
    else $error("latched stall did not pull pin low");
  a_report_drive: assert property ((prot == MFRL_PR_IDLE)
    && !tsd_active |=> gate_state == MFRL_GS_RUN)
    else $error("stage left run state without protection");
  a_speed_gate: assert property (!cfg.overspeed_check_enable
    |-> !cause_now.overspeed) else $error("disabled detector fired");

endmodule : mfrl_fault_resp

// ### verif/mfrl_ctrl_model.sv
// Controller model: AHB-Lite master doing single word transfers
`timescale 1ns/1ps
module mfrl_ctrl_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        go,
  input  wire logic        wr,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             done,
  output logic [31:0]      rdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [31:0]      hwdata
);
  logic [1:0] ph;  // 0 idle, 1 address phase, 2 data phase

  // Phases held until hready is seen high at a rising edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph     <= 2'h0;
      done   <= 1'b0;
      hsel   <= 1'b0;
      htrans <= 2'h0;
      haddr  <= 32'h0;
      hwrite <= 1'b0;
      hwdata <= 32'h0;
    end else begin
      done <= 1'b0;
      // Done guard stops a stale request restarting
      if (ph == 2'h0 && go && !done) begin
        ph     <= 2'h1;
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= addr;
        hwrite <= wr;
      end else if (ph == 2'h1 && hready) begin
        ph     <= 2'h2;
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wdata;
      end else if (ph == 2'h2 && hready) begin
        ph     <= 2'h0;
        rdata  <= hrdata;
        done   <= 1'b1;
        // Released data lines must not keep the old value
        hwdata <= ~hwdata;
      end
    end
  end
endmodule : mfrl_ctrl_model

// ### verif/mfrl_fault_resp_test.sv
// Self-checking bench for the motor fault-response block
`timescale 1ns/1ps
module mfrl_fault_resp_test;
  import mfrl_pkg::*;
  // Case row: config, detectors firing, status and pin expected
  typedef struct packed {
    logic [15:0] cfg;
    logic [2:0]  det;
    logic [15:0] st;
    logic        pin;
  } mfrl_row_t;
  logic        hclk, hresetn, go, wr, done, hsel, hwrite, hreadyout;
  logic        hresp, recirc_done, sync_loss_detect, no_load_detect;
  logic        charge_pump_en, fault_pin_n, irq;
  logic [31:0] addr, wdata, rdata, haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [11:0] csa_code;
  logic [15:0] motor_speed;
  mfrl_temp_t  temp_cmp;
  mfrl_gate_t  gate_state;
  int          fails, tests_run, cyc;
  mfrl_row_t   rows [13];

  mfrl_fault_resp #(.RETRY_UNIT_CYC(8)) u_mfrl_fault_resp (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .temp_cmp(temp_cmp), .recirc_done(recirc_done),
    .csa_code(csa_code), .motor_speed(motor_speed),
    .sync_loss_detect(sync_loss_detect), .no_load_detect(no_load_detect),
    .gate_state(gate_state), .charge_pump_en(charge_pump_en),
    .fault_pin_n(fault_pin_n), .irq(irq));

  mfrl_ctrl_model u_mfrl_ctrl_model (
    .hclk(hclk), .hresetn(hresetn), .go(go), .wr(wr), .addr(addr),
    .wdata(wdata), .hready(hreadyout), .hrdata(hrdata), .done(done),
    .rdata(rdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata));

  // Clock, 8 ns period
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // Hang guard, far beyond the expected run length
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic conclude();
    if (fails == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  // One transfer through the model; waits for its done pulse
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    go    <= 1'b1;
    wr    <= w;
    addr  <= a;
    wdata <= d;
    @(negedge hclk);
    while (!done) @(negedge hclk);
    @(posedge hclk);
    go <= 1'b0;
  endtask : bus

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask : rd

  task automatic temp(input logic [3:0] t);
    temp_cmp <= t;
    repeat (10) @(posedge hclk);
  endtask : temp

  initial begin
    {go, wr, recirc_done, sync_loss_detect, no_load_detect} = '0;
    {addr, wdata, csa_code, motor_speed, fails, tests_run, cyc} = '0;
    temp_cmp = '0;
    hresetn  = 1'b0;
    // Detector bits: 0 overspeed, 1 sync loss, 2 no load
    rows = '{'{16'h2f09, 3'h1, 16'h04c1, 1'b0},
             '{16'h2f19, 3'h1, 16'h08c1, 1'b0},
             '{16'h2f29, 3'h1, 16'h0cc1, 1'b0},
             '{16'h2f39, 3'h1, 16'h10c1, 1'b0},
             '{16'h2f49, 3'h1, 16'h04c1, 1'b0},
             '{16'h2f89, 3'h1, 16'h00c1, 1'b1},
             '{16'h2f99, 3'h1, 16'h0000, 1'b1},
             '{16'h2fa9, 3'h1, 16'h0000, 1'b1},
             '{16'h2fc9, 3'h1, 16'h0000, 1'b1},
             '{16'h0f09, 3'h1, 16'h0000, 1'b1},
             '{16'h4f09, 3'h2, 16'h0541, 1'b0},
             '{16'h8f09, 3'h4, 16'h0641, 1'b0},
             '{16'h2f09, 3'h2, 16'h0000, 1'b1}};
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(32'h00, 32'h00000099);
    rd(32'h04, 32'h0fffffff);
    rd(32'h1c, 32'h0);
    bus(1'b1, 32'h04, 32'h01000064);
    bus(1'b1, 32'h18, 32'hf);
    // Stall response for modes 0h-4h, 8h, 9h, Ah, Ch and every detector
    foreach (rows[i]) begin
      bus(1'b1, 32'h00, {16'h0, rows[i].cfg});
      motor_speed      <= rows[i].det[0] ? 16'h00c8 : 16'h0;
      sync_loss_detect <= rows[i].det[1];
      no_load_detect   <= rows[i].det[2];
      repeat (10) @(posedge hclk);
      rd(32'h08, {16'h0, rows[i].st});
      chk({31'h0, fault_pin_n}, {31'h0, rows[i].pin});
      {motor_speed, sync_loss_detect, no_load_detect} <= '0;
      bus(1'b1, 32'h0c, 32'h1);
      repeat (140) @(posedge hclk);
      rd(32'h08, 32'h0);
      chk({29'h0, gate_state}, {29'h0, MFRL_GS_RUN});
    end
    // Recirculation stage falls to all off once energy is gone
    bus(1'b1, 32'h00, 32'h2f19);
    motor_speed <= 16'h00c8;
    repeat (10) @(posedge hclk);
    recirc_done <= 1'b1;
    repeat (10) @(posedge hclk);
    chk({29'h0, gate_state}, {29'h0, MFRL_GS_OFF});
    {motor_speed, recirc_done} <= '0;
    bus(1'b1, 32'h0c, 32'h1);
    repeat (4) @(posedge hclk);
    chk({29'h0, gate_state}, {29'h0, MFRL_GS_RUN});
    // Interrupt raised, masked, cleared
    rd(32'h10, 32'h2);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, 32'h18, 32'h0);
    repeat (3) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, 32'h14, 32'hf);
    rd(32'h10, 32'h0);
    // Warning, pin report off then on
    bus(1'b1, 32'h00, 32'h99);
    temp(4'h3);
    rd(32'h08, 32'h00c);
    chk({31'h0, fault_pin_n}, 32'h1);
    bus(1'b1, 32'h0c, 32'h1);
    rd(32'h08, 32'h00c);
    temp(4'h0);
    bus(1'b1, 32'h0c, 32'h1);
    rd(32'h08, 32'h0);
    bus(1'b1, 32'h00, 32'h1099);
    temp(4'h3);
    chk({31'h0, fault_pin_n}, 32'h0);
    temp(4'h2);
    bus(1'b1, 32'h0c, 32'h1);
    rd(32'h08, 32'h0);
    chk({31'h0, fault_pin_n}, 32'h0);
    temp(4'h0);
    chk({31'h0, fault_pin_n}, 32'h1);
    // Shutdown, hysteresis release, sticky flag
    temp(4'hf);
    rd(32'h08, 32'h41e);
    chk({30'h0, charge_pump_en, fault_pin_n}, 32'h0);
    temp(4'h8);
    chk({29'h0, gate_state}, {29'h0, MFRL_GS_OFF});
    temp(4'h0);
    chk({30'h0, charge_pump_en, fault_pin_n}, 32'h3);
    rd(32'h08, 32'h01e);
    bus(1'b1, 32'h0c, 32'h1);
    rd(32'h08, 32'h0);
    // Lock current: short glitch, real event, ignore mode
    bus(1'b1, 32'h00, 32'h020098);
    csa_code <= 12'h200;
    repeat (100) @(posedge hclk);
    csa_code <= 12'h0;
    rd(32'h08, 32'h0);
    csa_code <= 12'h200;
    repeat (300) @(posedge hclk);
    csa_code <= 12'h0;
    rd(32'h08, 32'h021);
    bus(1'b1, 32'h0c, 32'h1);
    rd(32'h08, 32'h0);
    bus(1'b1, 32'h00, 32'h020099);
    csa_code <= 12'h200;
    repeat (300) @(posedge hclk);
    rd(32'h08, 32'h0);
    // Reset in mid-run: outputs idle, registers back to defaults
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk({26'h0, gate_state, charge_pump_en, fault_pin_n, irq}, 32'h6);
    hresetn <= 1'b1;
    rd(32'h00, 32'h00000099);
    rd(32'h08, 32'h0);
    chk({30'h0, hresp, hreadyout}, 32'h1);
    conclude();
  end
endmodule : mfrl_fault_resp_test
